// [hw/bvs_pkg.sv]
// package of constants and types for the bitplane video shifter
package bvs_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_PAL0 = 12'h000;  // entries 0..15, one word each
  localparam logic [11:0] OFS_MODE = 12'h040;  // resolution select
  localparam logic [11:0] OFS_SYNC = 12'h044;  // sync source select
  localparam logic [11:0] OFS_STAT = 12'h048;  // read-only status

  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam int PAL_RED_LSB = 8;
  localparam int PAL_GRN_LSB = 4;
  localparam int PAL_BLU_LSB = 0;
  localparam logic [11:0] PAL_RESET = 12'h000;
  localparam int SYNC_EXT_BIT = 0;
  localparam logic [1:0] RES_LOW = 2'h0;  // 320x200, four planes
  localparam logic [1:0] RES_MED = 2'h1;  // 640x200, two planes
  localparam logic [1:0] RES_HIGH = 2'h2;  // 640x400, one plane
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [4:0] PIX_PER_WORD = 5'h10;

  // shifter run state, one-hot
  typedef enum logic [1:0] {
    BVS_IDLE = 2'b01,
    BVS_RUN = 2'b10
  } bvs_run_t;

endpackage : bvs_pkg

// [hw/bvs_sync2.sv]
// two-stage synchroniser for pins entering the pixel clock domain
`timescale 1ns/1ps
module bvs_sync2 import bvs_pkg::*; #(
  parameter int W = 1
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;  // metastable stage, read only by s2
    logic [W-1:0] s2;  // settled stage
  } bvs_sync_t;

  bvs_sync_t r;
  bvs_sync_t next_r;

  // next-state: shift the pins through both stages
  always_comb begin
    next_r = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  // registers, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign q = r.s2;

endmodule : bvs_sync2

// [hw/bvs_shifter.sv]
// bitplane video shifter: palette, plane shifter, sync routing, apb slave
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module bvs_shifter import bvs_pkg::*; (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory controller side
  input wire logic shift_load_strobe,
  input wire logic [15:0] load_data,
  input wire logic palette_select,
  // timing unit side
  input wire logic display_window_active,
  input wire logic blank,
  input wire logic pixel_tick,
  input wire logic vsync_in,
  input wire logic hsync_in,
  // monitor connector pins
  input wire logic mono_monitor_sense,
  input wire logic ext_vsync,
  input wire logic ext_hsync,
  // video outputs
  output logic [3:0] red,
  output logic [3:0] green,
  output logic [3:0] blue,
  output logic mono_out,
  output logic mon_vsync,
  output logic mon_hsync,
  output logic rf_vsync,
  output logic rf_hsync
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------

  // planes fetched per sixteen pixels
  function automatic logic [2:0] plane_count(input logic [1:0] res, input logic mono);
    logic [2:0] n;
    n = 3'h1;
    if (!mono && res == RES_LOW) begin
      n = 3'h4;
    end else if (!mono && res == RES_MED) begin
      n = 3'h2;
    end
    return n;
  endfunction : plane_count

  // keep only the index bits of the active planes
  function automatic logic [3:0] pix_index(input logic [3:0] bits, input logic [2:0] np);
    logic [3:0] i;
    i = {3'h0, bits[0]};
    if (np == 3'h4) begin
      i = bits;
    end else if (np == 3'h2) begin
      i = {2'h0, bits[1:0]};
    end
    return i;
  endfunction : pix_index

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0][11:0] pal;  // palette, {red, green, blue}
    logic [1:0] res;  // resolution select
    logic ext_sync;  // external sync source
    logic [3:0][15:0] stage;  // words collected for the next group
    logic [1:0] ld_cnt;  // plane slot of the next load
    logic stage_full;  // a whole group waits in stage
    logic [3:0][15:0] shf;  // words being shifted out
    logic [4:0] pix_left;  // pixels left in shf
    bvs_run_t st;  // shifter state
    logic [3:0] red;
    logic [3:0] green;
    logic [3:0] blue;
    logic mono;
    logic vs;
    logic hs;
    logic [31:0] prdata;  // captured in the setup phase
    logic perr;  // unmapped address seen in setup
  } bvs_state_t;

  bvs_state_t r;
  bvs_state_t next_r;

  // synchronised pins
  logic [2:0] sync_q;
  logic sense_s;
  logic ext_vs_s;
  logic ext_hs_s;

  // decode helpers
  logic pal_hit;
  logic wr_en;
  logic mono_act;
  logic [2:0] np;
  logic [3:0] idx;
  logic [11:0] pix_col;
  logic load_ok;
  logic last_pix;
  logic xfer;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  bvs_sync2 #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d({mono_monitor_sense, ext_vsync, ext_hsync}),
    .q(sync_q)
  );

  assign sense_s = sync_q[2];
  assign ext_vs_s = sync_q[1];
  assign ext_hs_s = sync_q[0];

  // ----------------------------------------
  // combinational decode
  // ----------------------------------------
  assign mono_act = (r.res == RES_HIGH) || !sense_s;
  assign np = plane_count(r.res, mono_act);
  // first loaded plane sits in shf[0], the index lsb
  assign idx = pix_index({r.shf[3][0], r.shf[2][0], r.shf[1][0], r.shf[0][0]}, np);
  // idx is masked to the active planes, so medium never reaches entry four
  assign pix_col = r.pal[idx];
  assign pal_hit = (paddr[11:6] == OFS_PAL0[11:6]) && (paddr[1:0] == 2'h0);
  assign wr_en = psel && penable && pwrite && !r.perr;
  // no back-pressure: a source that outruns the pixels overwrites the stage
  assign load_ok = shift_load_strobe && display_window_active;
  assign last_pix = pixel_tick && (r.st == BVS_RUN) && (r.pix_left == 5'h01);
  assign xfer = r.stage_full && ((r.st == BVS_IDLE) || last_pix);

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    next_r = r;

    // setup phase: capture read data and address check
    if (psel && !penable) begin
      next_r.perr = 1'b1;
      next_r.prdata = 32'h0;
      if (pal_hit) begin
        next_r.perr = 1'b0;
        next_r.prdata = {20'h0, r.pal[paddr[5:2]]};
      end else if (paddr == OFS_MODE) begin
        next_r.perr = 1'b0;
        next_r.prdata = {30'h0, r.res};
      end else if (paddr == OFS_SYNC) begin
        next_r.perr = 1'b0;
        next_r.prdata = {31'h0, r.ext_sync};
      end else if (paddr == OFS_STAT) begin
        next_r.perr = 1'b0;
        next_r.prdata = {28'h0, r.st == BVS_RUN, r.stage_full, mono_act, sense_s};
      end
    end

    // access phase: writes land here, palette needs its select
    if (wr_en) begin
      if (pal_hit && palette_select) begin
        next_r.pal[paddr[5:2]] = pwdata[11:0];
      end else if (paddr == OFS_MODE) begin
        next_r.res = pwdata[1:0];
      end else if (paddr == OFS_SYNC) begin
        next_r.ext_sync = pwdata[SYNC_EXT_BIT];
      end
    end

    // shift one pixel out on each tick
    // shifting goes on under blank, so the group pace stays tied to the ticks
    if (pixel_tick && r.st == BVS_RUN) begin
      for (int p = 0; p < 4; p++) begin
        next_r.shf[p] = {1'b0, r.shf[p][15:1]};
      end
      next_r.pix_left = r.pix_left - 5'h01;
      if (r.pix_left == 5'h01) begin
        next_r.st = BVS_IDLE;
      end
    end

    // hand a complete group to the shifter
    if (xfer) begin
      next_r.shf = r.stage;
      next_r.pix_left = PIX_PER_WORD;
      next_r.st = BVS_RUN;
      next_r.stage_full = 1'b0;
    end

    // collect plane words; a completing load beats the hand-over clear
    if (load_ok) begin
      next_r.stage[r.ld_cnt] = load_data;
      if (r.ld_cnt == 2'(np - 3'h1)) begin
        next_r.ld_cnt = 2'h0;
        next_r.stage_full = 1'b1;
      end else begin
        next_r.ld_cnt = r.ld_cnt + 2'h1;
      end
    end

    // pixel colour, looked up from the palette as it stands now
    if (pixel_tick && r.st == BVS_RUN) begin
      if (mono_act) begin
        next_r.mono = r.shf[0][0] ^ r.pal[0][0];
        next_r.red = 4'h0;
        next_r.green = 4'h0;
        next_r.blue = 4'h0;
      end else begin
        next_r.mono = 1'b0;
        next_r.red = pix_col[PAL_RED_LSB +: 4];
        next_r.green = pix_col[PAL_GRN_LSB +: 4];
        next_r.blue = pix_col[PAL_BLU_LSB +: 4];
      end
    end

    // blanking wins over any pixel
    if (blank) begin
      next_r.red = 4'h0;
      next_r.green = 4'h0;
      next_r.blue = 4'h0;
      next_r.mono = 1'b0;
    end

    // sync source select
    next_r.vs = r.ext_sync ? ext_vs_s : vsync_in;
    next_r.hs = r.ext_sync ? ext_hs_s : hsync_in;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // whole state frozen while ce is low, the synchronisers included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.pal <= {16{PAL_RESET}};
      r.res <= MODE_RESET;
      r.st <= BVS_IDLE;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // zero-wait slave: access phase always completes at once
  assign pready = 1'b1;
  assign pslverr = psel && penable && r.perr;
  assign prdata = r.prdata;
  assign red = r.red;
  assign green = r.green;
  assign blue = r.blue;
  assign mono_out = r.mono;
  // same registered sync on both connectors keeps them aligned
  assign mon_vsync = r.vs;
  assign mon_hsync = r.hs;
  assign rf_vsync = r.vs;
  assign rf_hsync = r.hs;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pixel;
    ce && pixel_tick && r.st == BVS_RUN && !blank;
  endsequence

  sequence s_pal_write;
    ce && wr_en && pal_hit && palette_select;
  endsequence

  a_blank_dark: assert property (
    ce && blank |=> red == 4'h0 && green == 4'h0 && blue == 4'h0 && !mono_out)
    else $error("video not dark during blank");

  a_mono_no_colour: assert property (
    s_pixel and mono_act |=> red == 4'h0 && green == 4'h0 && blue == 4'h0)
    else $error("colour outputs driven in monochrome");

  a_mono_invert: assert property (
    s_pixel and mono_act |=> mono_out == ($past(r.shf[0][0]) ^ $past(r.pal[0][0])))
    else $error("monochrome pixel or inversion wrong");

  a_palette_colour: assert property (
    s_pixel and !mono_act |=> {red, green, blue} == $past(pix_col))
    else $error("pixel colour does not match palette entry");

  a_medium_four: assert property (
    r.res == RES_MED && !mono_act |-> idx[3:2] == 2'h0)
    else $error("medium resolution used an entry above three");

  a_palette_write: assert property (
    s_pal_write |=> r.pal[$past(paddr[5:2])] == $past(pwdata[11:0]))
    else $error("palette write lost");

  a_load_gated: assert property (
    !display_window_active |=> $stable(r.ld_cnt) && $stable(r.stage))
    else $error("word taken outside display window");

  a_group_full: assert property (
    ce && load_ok && r.ld_cnt == 2'(np - 3'h1) |=> r.stage_full && r.ld_cnt == 2'h0)
    else $error("plane group did not complete");

  a_group_sixteen: assert property (
    ce && xfer |=> r.pix_left == PIX_PER_WORD && r.st == BVS_RUN)
    else $error("group not sixteen pixels");

  a_sense_mono: assert property (
    !sense_s |-> mono_act && np == 3'h1)
    else $error("sensed monochrome monitor not honoured");

  a_ext_sync: assert property (
    ce && r.ext_sync |=> mon_vsync == $past(ext_vs_s) && rf_hsync == $past(ext_hs_s))
    else $error("external sync not routed");

  a_int_sync: assert property (
    ce && !r.ext_sync |=> rf_vsync == $past(vsync_in) && mon_hsync == $past(hsync_in))
    else $error("internal sync not routed to both connectors");

  a_load_word: assert property (
    ce && load_ok |=> r.stage[$past(r.ld_cnt)] == $past(load_data))
    else $error("loaded word not stored in its plane slot");

  a_shift_step: assert property (
    ce && pixel_tick && r.st == BVS_RUN && !last_pix |=> r.shf[0] == ($past(r.shf[0]) >> 1))
    else $error("plane word did not advance by one pixel");

  a_group_end: assert property (
    ce && last_pix && !r.stage_full |=> r.st == BVS_IDLE)
    else $error("shifter ran past sixteen pixels");

endmodule : bvs_shifter

// [verification/bvs_feeder.sv]
// partner model: memory controller that feeds plane words to the shifter
`timescale 1ns/1ps
module bvs_feeder (
  // clock and frame timing
  input wire logic pclk,
  input wire logic vsync,
  // load stream towards the shifter
  output logic shift_load_strobe,
  output logic [15:0] load_data,
  output logic display_window_active
);
  // buffer start written by software, and the running fetch pointer (byte addresses)
  logic [23:0] video_base = 24'h000000;
  logic [23:0] fetch_addr = 24'h000000;

  // software sets the start before any fetch; any word boundary will do
  task automatic set_base(input logic [23:0] a);
    @(posedge pclk);
    video_base <= a;
  endtask : set_base

  // pointer reloads in vertical blank and steps one word per accepted load
  always @(posedge pclk) begin
    if (vsync) begin
      fetch_addr <= video_base;
    end else if (shift_load_strobe && display_window_active) begin
      fetch_addr <= fetch_addr + 24'h000002;
    end
  end

  // ----------------------------------------
  // word stream
  // ----------------------------------------
  // idle value is arbitrary; after a group the bus shows the inverse of the last word
  initial begin
    shift_load_strobe = 1'b0;
    display_window_active = 1'b0;
    load_data = 16'hA5A5;
  end

  // one group: n interleaved plane words from a contiguous buffer, one per strobe
  task automatic send_group(input int n, input logic [63:0] ws);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      shift_load_strobe <= 1'b1;
      display_window_active <= 1'b1;
      load_data <= ws[16*i+:16];
    end
    @(posedge pclk);
    // released bus must not keep the old word, or a late latch would go unseen
    shift_load_strobe <= 1'b0;
    display_window_active <= 1'b0;
    load_data <= ~load_data;
  endtask : send_group

  // a strobe with the window shut: the shifter must let it pass
  task automatic send_stray(input logic [15:0] w);
    @(posedge pclk);
    shift_load_strobe <= 1'b1;
    load_data <= w;
    @(posedge pclk);
    shift_load_strobe <= 1'b0;
    load_data <= ~w;
  endtask : send_stray
endmodule : bvs_feeder

// [verification/bitplane_video_shifter_bench.sv]
// self-checking bench for the bitplane video shifter
`timescale 1ns/1ps
module bitplane_video_shifter_bench import bvs_pkg::*;;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic rerr, palette_select, blank, pixel_tick, vsync_in, hsync_in;
  logic mono_monitor_sense, ext_vsync, ext_hsync, mono_out;
  logic mon_vsync, mon_hsync, rf_vsync, rf_hsync;
  logic shift_load_strobe, display_window_active;
  logic [15:0] load_data;
  logic [3:0] red, green, blue;
  logic ce;  // clock enable, dropped once to check the freeze
  int error_cnt = 0;
  int tests_run = 0;

  // 200 MHz pixel clock
  always #2.5 pclk = ~pclk;

  bvs_shifter uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_load_strobe(shift_load_strobe), .load_data(load_data),
    .palette_select(palette_select), .display_window_active(display_window_active),
    .blank(blank), .pixel_tick(pixel_tick), .vsync_in(vsync_in), .hsync_in(hsync_in),
    .mono_monitor_sense(mono_monitor_sense), .ext_vsync(ext_vsync),
    .ext_hsync(ext_hsync), .red(red), .green(green), .blue(blue), .mono_out(mono_out),
    .mon_vsync(mon_vsync), .mon_hsync(mon_hsync), .rf_vsync(rf_vsync),
    .rf_hsync(rf_hsync));

  bvs_feeder feed (.pclk(pclk), .vsync(vsync_in), .shift_load_strobe(shift_load_strobe),
    .load_data(load_data), .display_window_active(display_window_active));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer; sel raises palette select for palette writes only
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic sel);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    palette_select <= sel;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    palette_select <= 1'b0;
  endtask : apb

  // let n edges pass, then look once their updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : step

  // one pixel advance; output is read after the edge that registers it
  task automatic tick();
    @(posedge pclk);
    pixel_tick <= 1'b1;
    @(posedge pclk);
    pixel_tick <= 1'b0;
    #1;
  endtask : tick

  // colour outputs against a palette word
  task automatic rgb(input logic [11:0] p);
    chk("rgb", {20'h0, red, green, blue},
        {20'h0, p[PAL_RED_LSB+:4], p[PAL_GRN_LSB+:4], p[PAL_BLU_LSB+:4]});
  endtask : rgb

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // whole sequence needs under two hundred cycles; cut a hang after 20000
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, palette_select, blank, pixel_tick} = 6'h00;
    ce = 1'b1;
    {vsync_in, hsync_in, ext_vsync} = 3'h0;
    {ext_hsync, mono_monitor_sense} = 2'h3;  // colour monitor attached
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // registers: reset values, gated palette writes, unmapped place
    apb(1'b0, OFS_PAL0 + 12'h028, 32'h0, 1'b0);
    chk("pal10 reset", rdat, {20'h0, PAL_RESET});
    apb(1'b0, OFS_MODE, 32'h0, 1'b0);
    chk("mode reset", rdat, {30'h0, MODE_RESET});
    apb(1'b1, OFS_PAL0 + 12'h028, 32'hFFF, 1'b0);
    apb(1'b0, OFS_PAL0 + 12'h028, 32'h0, 1'b0);
    chk("pal10 ungated", rdat, {20'h0, PAL_RESET});
    apb(1'b1, OFS_PAL0 + 12'h014, 32'h123, 1'b1);
    apb(1'b1, OFS_PAL0 + 12'h028, 32'hABC, 1'b1);
    apb(1'b1, OFS_PAL0 + 12'h004, 32'h456, 1'b1);
    apb(1'b0, OFS_PAL0 + 12'h028, 32'h0, 1'b0);
    chk("pal10", rdat, 32'hABC);
    apb(1'b0, 12'h04C, 32'h0, 1'b0);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    chk("unmapped data", rdat, 32'h0);
    $display("test registers done");
    // low res: pixel 0 index 5, pixel 1 index 10
    feed.set_base(24'h012340);
    feed.send_group(4, {16'h0002, 16'h0001, 16'h0002, 16'h0001});
    step(3);
    tick();
    rgb(12'h123);
    tick();
    rgb(12'hABC);
    @(posedge pclk);
    blank <= 1'b1;
    step(1);
    rgb(12'h000);
    @(posedge pclk);
    blank <= 1'b0;
    repeat (14) tick();
    $display("test low resolution done");
    // high res: palette bypassed, entry 0 bit 0 inverts later pixels only
    apb(1'b1, OFS_MODE, {30'h0, RES_HIGH}, 1'b0);
    feed.send_group(1, {48'h0, 16'h0003});
    step(3);
    tick();
    chk("mono p0", {31'h0, mono_out}, 32'h1);
    rgb(12'h000);
    apb(1'b1, OFS_PAL0, 32'h1, 1'b1);
    step(1);
    chk("mono held", {31'h0, mono_out}, 32'h1);
    // a tick while ce is low must not move the shifter
    @(posedge pclk);
    ce <= 1'b0;
    tick();
    chk("ce freeze", {31'h0, mono_out}, 32'h1);
    @(posedge pclk);
    ce <= 1'b1;
    tick();
    chk("mono inv", {31'h0, mono_out}, 32'h0);
    repeat (14) tick();
    // medium res: two planes, pixel 0 index 1
    apb(1'b1, OFS_MODE, {30'h0, RES_MED}, 1'b0);
    feed.send_group(2, {32'h0, 16'h0000, 16'h0001});
    step(3);
    tick();
    rgb(12'h456);
    $display("test mono and medium done");
    // sync routing, internal then external source
    @(posedge pclk);
    vsync_in <= 1'b1;
    step(1);
    chk("int sync", {28'h0, mon_vsync, rf_vsync, mon_hsync, rf_hsync}, 32'hC);
    apb(1'b1, OFS_SYNC, 32'h1, 1'b0);
    step(4);
    chk("ext sync", {28'h0, mon_vsync, rf_vsync, mon_hsync, rf_hsync}, 32'h3);
    // monitor sense low means monochrome; vsync ends, so the fetch pointer runs again
    @(posedge pclk);
    mono_monitor_sense <= 1'b0;
    vsync_in <= 1'b0;
    step(4);
    apb(1'b0, OFS_STAT, 32'h0, 1'b0);
    chk("status", {28'h0, rdat[3:0]}, 32'hA);
    // strobe outside the window is dropped, a real word fills the stage
    feed.send_stray(16'h0001);
    apb(1'b0, OFS_STAT, 32'h0, 1'b0);
    chk("status stray", {28'h0, rdat[3:0]}, 32'hA);
    feed.send_group(1, {48'h0, 16'h0001});
    apb(1'b0, OFS_STAT, 32'h0, 1'b0);
    chk("status loaded", {28'h0, rdat[3:0]}, 32'hE);
    chk("fetch addr", {8'h0, feed.fetch_addr}, 32'h00012342);
    $display("test sync and sense done");
    test_done();
  end
endmodule : bitplane_video_shifter_bench
